/* File: core/cdp_top.sv */
// codec digital path: control registers, input iir filters, output modulators
// Functional notes
// - four-bit bias voltage code, sixteen steps from lowest to highest level.
// - separate four-bit bias current code, sixteen steps of output current.
// - bias output enabled only while a microphone capture is active.
// - input gain below 24 dB selects line-input mode automatically.
// - line-input mode switches off the first input amplifier stage.
// - sixteen-bit pcm at any sample rate becomes a one-bit output stream.
// - three-bit output gain code drives the divider, about 3 dB steps.
// - channel A is standard mono, channel B is auxiliary mono.
// - the unused channel can be disabled to save power.
// - side tone adds attenuated mic signal; enable, gain, tap point set.
// - input path has two cascaded second-order iir sections.
// - filter configuration is ten words: gain, eight coefficients, dc flag.
// - gain and coefficients are twelve-bit signed two's complement.
// - binary point between bits 10 and 9; range -2 to under +2.
// - response is gain times two biquads with unit leading terms.
// - dc blocking multiplies the response by a first difference.
// - word 0 gain, words 1-2 first numerator, 3 first a1, 9 dc flag.
// - two filter instances, each configured and enabled on its own.
`timescale 1ns/100ps
`include "cdp_regs.svh"
module cdp_top
   import cdp_pkg::*;
#(
   parameter int NUM_CH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // capture samples from the input converters
   input wire logic adc_valid,
   input wire logic [15:0] adc_a,
   input wire logic [15:0] adc_b,
   // filtered capture samples
   output logic filt_valid,
   output logic [15:0] filt_a,
   output logic [15:0] filt_b,
   // playback samples, one strobe per sample at any rate
   input wire logic dac_valid,
   input wire logic [15:0] dac_left,
   input wire logic [15:0] dac_right,
   // output bitstreams to the analog output stage
   output logic left_out_pos,
   output logic left_out_neg,
   output logic right_out_pos,
   output logic right_out_neg,
   // analog controls
   output logic output_a,
   output logic [3:0] bias_voltage_code,
   output logic [3:0] bias_current_code,
   output logic line_mode,
   output logic amp1_enable,
   output logic [3:0] in_gain_code,
   output logic [2:0] out_gain_code,
   output logic adc_a_enable,
   output logic adc_b_enable
);

   // reset release through two flip-flops
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // saturate a wide value to a sample
   function automatic cdp_sample_t sat16(input cdp_acc_t v);
      if (v > 40'sd32767) begin
         sat16 = 16'sh7fff;
      end else if (v < -40'sd32768) begin
         sat16 = -16'sh8000;
      end else begin
         sat16 = cdp_sample_t'(v[15:0]);
      end
   endfunction : sat16

   // direct form one biquad, leading coefficients fixed at one
   function automatic cdp_sample_t biquad(
      input cdp_sample_t x, input cdp_sample_t x1, input cdp_sample_t x2,
      input cdp_sample_t y1, input cdp_sample_t y2,
      input cdp_coef_t b1, input cdp_coef_t b2,
      input cdp_coef_t a1, input cdp_coef_t a2);
      cdp_acc_t acc;
      acc = (cdp_acc_t'(x) <<< `CDP_FRAC)
         + cdp_acc_t'(b1) * cdp_acc_t'(x1)
         + cdp_acc_t'(b2) * cdp_acc_t'(x2)
         - cdp_acc_t'(a1) * cdp_acc_t'(y1)
         - cdp_acc_t'(a2) * cdp_acc_t'(y2);
      biquad = sat16(acc >>> `CDP_FRAC);
   endfunction : biquad

   // control registers
   logic [15:0] ctrl_q, ctrl_d;
   logic [15:0] bias_q, bias_d;
   logic [15:0] gain_q, gain_d;
   logic [15:0] st_q, st_d;
   cdp_coef_t coef_q [NUM_CH][`CDP_NUM_WORDS];
   cdp_coef_t coef_d [NUM_CH][`CDP_NUM_WORDS];
   logic [15:0] rdata_d;
   logic [7:0] off_a, off_b;
   logic hit_a, hit_b;

   assign off_a = reg_addr - `CDP_ADDR_FILT_A;
   assign off_b = reg_addr - `CDP_ADDR_FILT_B;
   assign hit_a = (reg_addr >= `CDP_ADDR_FILT_A) && (off_a < `CDP_FILT_SPAN)
      && (reg_addr[1:0] == 2'b00);
   assign hit_b = (reg_addr >= `CDP_ADDR_FILT_B) && (off_b < `CDP_FILT_SPAN)
      && (reg_addr[1:0] == 2'b00);

   // status word assembled from the block's live state
   logic line_mode_now, mic_active;
   logic [15:0] status_w;

   assign mic_active = ctrl_q[`CDP_CTRL_MIC_EN]
      && (ctrl_q[`CDP_CTRL_CHA_EN] || ctrl_q[`CDP_CTRL_CHB_EN]);
   assign line_mode_now =
      gain_q[`CDP_GAIN_IN_LSB +: 4] < `CDP_LINE_GAIN_CODE;
   assign status_w = {12'h000, output_a, amp1_enable, line_mode,
      mic_active};

   always_comb begin
      ctrl_d = ctrl_q;
      bias_d = bias_q;
      gain_d = gain_q;
      st_d = st_q;
      coef_d = coef_q;
      if (reg_wr) begin
         case (reg_addr)
            `CDP_ADDR_CTRL: ctrl_d = {8'h00, reg_wdata[7:0]};
            `CDP_ADDR_BIAS: bias_d = {8'h00, reg_wdata[7:0]};
            `CDP_ADDR_GAIN: gain_d = {9'h000, reg_wdata[6:0]};
            `CDP_ADDR_SIDETONE: st_d = {12'h000, reg_wdata[3:0]};
            default: begin
               // words 0-8 follow the order gain, b01 b02 a01 a02 b11 ...
               if (hit_a) begin
                  coef_d[0][off_a[5:2]] = (off_a[5:2] == 4'(`CDP_W_DC)) ?
                     {11'h000, reg_wdata[0]} : reg_wdata[11:0];
               end
               if (hit_b) begin
                  coef_d[1][off_b[5:2]] = (off_b[5:2] == 4'(`CDP_W_DC)) ?
                     {11'h000, reg_wdata[0]} : reg_wdata[11:0];
               end
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `CDP_ADDR_CTRL: rdata_d = ctrl_q;
            `CDP_ADDR_BIAS: rdata_d = bias_q;
            `CDP_ADDR_GAIN: rdata_d = gain_q;
            `CDP_ADDR_SIDETONE: rdata_d = st_q;
            `CDP_ADDR_STATUS: rdata_d = status_w;
            default: begin
               if (hit_a) begin
                  rdata_d = {{4{coef_q[0][off_a[5:2]][11]}},
                     coef_q[0][off_a[5:2]]};
               end else if (hit_b) begin
                  rdata_d = {{4{coef_q[1][off_b[5:2]][11]}},
                     coef_q[1][off_b[5:2]]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `CDP_CTRL_RESET;
         bias_q <= `CDP_BIAS_RESET;
         gain_q <= `CDP_GAIN_RESET;
         st_q <= `CDP_SIDETONE_RESET;
         reg_rdata <= 16'h0000;
         for (int c = 0; c < NUM_CH; c++) begin
            for (int w = 0; w < `CDP_NUM_WORDS; w++) begin
               coef_q[c][w] <= (w == `CDP_W_GAIN) ? `CDP_UNITY : 12'h000;
            end
         end
      end else begin
         ctrl_q <= ctrl_d;
         bias_q <= bias_d;
         gain_q <= gain_d;
         st_q <= st_d;
         coef_q <= coef_d;
         reg_rdata <= rdata_d;
      end
   end

   // input filters, one per channel
   cdp_sample_t x_in [NUM_CH];
   logic [NUM_CH-1:0] filt_en, ch_en;
   cdp_sample_t x1_q [NUM_CH][2], x2_q [NUM_CH][2];
   cdp_sample_t y1_q [NUM_CH][2], y2_q [NUM_CH][2];
   cdp_sample_t x1_d [NUM_CH][2], x2_d [NUM_CH][2];
   cdp_sample_t y1_d [NUM_CH][2], y2_d [NUM_CH][2];
   cdp_sample_t dc_q [NUM_CH], dc_d [NUM_CH];
   cdp_sample_t out_q [NUM_CH], out_d [NUM_CH];
   logic fv_q, fv_d;

   assign x_in[0] = adc_a;
   assign x_in[1] = adc_b;
   assign filt_en = {ctrl_q[`CDP_CTRL_FILT_B_EN], ctrl_q[`CDP_CTRL_FILT_A_EN]};
   assign ch_en = {ctrl_q[`CDP_CTRL_CHB_EN], ctrl_q[`CDP_CTRL_CHA_EN]};

   always_comb begin
      cdp_sample_t g, s1, s2;
      cdp_acc_t dif;
      g = '0;
      s1 = '0;
      s2 = '0;
      dif = '0;
      x1_d = x1_q;
      x2_d = x2_q;
      y1_d = y1_q;
      y2_d = y2_q;
      dc_d = dc_q;
      out_d = out_q;
      fv_d = adc_valid;
      for (int c = 0; c < NUM_CH; c++) begin
         g = sat16((cdp_acc_t'(coef_q[c][`CDP_W_GAIN])
            * cdp_acc_t'(x_in[c])) >>> `CDP_FRAC);
         s1 = biquad(g, x1_q[c][0], x2_q[c][0], y1_q[c][0], y2_q[c][0],
            coef_q[c][`CDP_W_B01], coef_q[c][`CDP_W_B02],
            coef_q[c][`CDP_W_A01], coef_q[c][`CDP_W_A02]);
         s2 = biquad(s1, x1_q[c][1], x2_q[c][1], y1_q[c][1], y2_q[c][1],
            coef_q[c][`CDP_W_B11], coef_q[c][`CDP_W_B12],
            coef_q[c][`CDP_W_A11], coef_q[c][`CDP_W_A12]);
         dif = cdp_acc_t'(s2) - cdp_acc_t'(dc_q[c]);
         if (adc_valid && ch_en[c]) begin
            if (filt_en[c]) begin
               x1_d[c][0] = g;
               x2_d[c][0] = x1_q[c][0];
               y1_d[c][0] = s1;
               y2_d[c][0] = y1_q[c][0];
               x1_d[c][1] = s1;
               x2_d[c][1] = x1_q[c][1];
               y1_d[c][1] = s2;
               y2_d[c][1] = y1_q[c][1];
               dc_d[c] = s2;
               out_d[c] = coef_q[c][`CDP_W_DC][0] ? sat16(dif) : s2;
            end else begin
               out_d[c] = x_in[c];
            end
         end else if (!ch_en[c]) begin
            out_d[c] = '0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fv_q <= 1'b0;
         for (int c = 0; c < NUM_CH; c++) begin
            out_q[c] <= '0;
            dc_q[c] <= '0;
            for (int s = 0; s < 2; s++) begin
               x1_q[c][s] <= '0;
               x2_q[c][s] <= '0;
               y1_q[c][s] <= '0;
               y2_q[c][s] <= '0;
            end
         end
      end else begin
         fv_q <= fv_d;
         out_q <= out_d;
         dc_q <= dc_d;
         x1_q <= x1_d;
         x2_q <= x2_d;
         y1_q <= y1_d;
         y2_q <= y2_d;
      end
   end

   assign filt_valid = fv_q;
   assign filt_a = out_q[0];
   assign filt_b = out_q[1];

   // side tone and output modulators
   cdp_sample_t st_src, st_add, pb_in [NUM_CH];
   cdp_sample_t hold_q [NUM_CH], hold_d [NUM_CH];
   logic [15:0] acc_q [NUM_CH], acc_d [NUM_CH];
   logic [NUM_CH-1:0] bit_q, bit_d;
   logic st_on, st_live;

   assign pb_in[0] = dac_left;
   assign pb_in[1] = dac_right;
   assign st_on = ctrl_q[`CDP_CTRL_ST_EN] && ch_en[0];
   // tap after the input converter uses the raw sample, else the filtered one
   assign st_src = ctrl_q[`CDP_CTRL_ST_TAP_IN] ? cdp_sample_t'(adc_a)
      : out_q[0];
   assign st_add = st_on ? sat16((cdp_acc_t'(st_src)
      * cdp_acc_t'({1'b0, st_q[3:0]})) >>> `CDP_ST_SHIFT) : '0;
   // joining after the converter mixes every cycle, not only per sample
   assign st_live = ctrl_q[`CDP_CTRL_ST_TAP_OUT];

   always_comb begin
      cdp_sample_t mix;
      logic [16:0] sum;
      mix = '0;
      sum = '0;
      hold_d = hold_q;
      acc_d = acc_q;
      bit_d = bit_q;
      for (int c = 0; c < NUM_CH; c++) begin
         if (dac_valid) begin
            hold_d[c] = (c == 0 && !st_live) ? sat16(cdp_acc_t'(pb_in[c])
               + cdp_acc_t'(st_add)) : pb_in[c];
         end
         mix = (c == 0 && st_live) ? sat16(cdp_acc_t'(hold_q[c])
            + cdp_acc_t'(st_add)) : hold_q[c];
         // first-order modulator: carry of offset-binary accumulation
         sum = {1'b0, acc_q[c]} + {1'b0, ~mix[15], mix[14:0]};
         if (ch_en[c]) begin
            acc_d[c] = sum[15:0];
            bit_d[c] = sum[16];
         end else begin
            acc_d[c] = '0;
            bit_d[c] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_q <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            hold_q[c] <= '0;
            acc_q[c] <= '0;
         end
      end else begin
         bit_q <= bit_d;
         hold_q <= hold_d;
         acc_q <= acc_d;
      end
   end

   // differential pins; a disabled channel sits at zero on both legs
   logic [3:0] pins_q, pins_d;
   logic [7:0] ana_q, ana_d;
   logic [6:0] gcode_q, gcode_d;

   always_comb begin
      pins_d = {bit_q[1] & ch_en[1], ~bit_q[1] & ch_en[1],
         bit_q[0] & ch_en[0], ~bit_q[0] & ch_en[0]};
      ana_d = {bias_q[`CDP_BIAS_CUR_LSB +: 4],
         bias_q[`CDP_BIAS_VOLT_LSB +: 4]};
      gcode_d = {gain_q[`CDP_GAIN_OUT_LSB +: 3],
         gain_q[`CDP_GAIN_IN_LSB +: 4]};
   end

   logic bias_on_q, line_q, amp1_q;
   logic [1:0] adc_en_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pins_q <= 4'h0;
         ana_q <= 8'h00;
         gcode_q <= 7'h00;
         bias_on_q <= 1'b0;
         line_q <= 1'b0;
         amp1_q <= 1'b0;
         adc_en_q <= 2'b00;
      end else begin
         pins_q <= pins_d;
         ana_q <= ana_d;
         gcode_q <= gcode_d;
         bias_on_q <= mic_active;
         line_q <= line_mode_now;
         amp1_q <= !line_mode_now && mic_active;
         adc_en_q <= ch_en;
      end
   end

   assign right_out_pos = pins_q[3];
   assign right_out_neg = pins_q[2];
   assign left_out_pos = pins_q[1];
   assign left_out_neg = pins_q[0];
   assign bias_voltage_code = ana_q[3:0];
   assign bias_current_code = ana_q[7:4];
   assign out_gain_code = gcode_q[6:4];
   assign in_gain_code = gcode_q[3:0];
   assign output_a = bias_on_q;
   assign line_mode = line_q;
   assign amp1_enable = amp1_q;
   assign adc_a_enable = adc_en_q[0];
   assign adc_b_enable = adc_en_q[1];

endmodule : cdp_top

/* File: shared/cdp_pkg.sv */
// types shared by the codec digital path
package cdp_pkg;
   typedef logic signed [11:0] cdp_coef_t;
   typedef logic signed [15:0] cdp_sample_t;
   typedef logic signed [39:0] cdp_acc_t;
endpackage : cdp_pkg

/* File: shared/cdp_regs.svh */
// register offsets, field positions, reset values and constants of the path
`ifndef CDP_REGS_SVH
`define CDP_REGS_SVH

`define CDP_ADDR_CTRL 8'h00
`define CDP_ADDR_BIAS 8'h04
`define CDP_ADDR_GAIN 8'h08
`define CDP_ADDR_SIDETONE 8'h0c
`define CDP_ADDR_STATUS 8'h10
`define CDP_ADDR_FILT_A 8'h40
`define CDP_ADDR_FILT_B 8'h80
`define CDP_FILT_SPAN 8'h28

`define CDP_CTRL_CHA_EN 0
`define CDP_CTRL_CHB_EN 1
`define CDP_CTRL_MIC_EN 2
`define CDP_CTRL_FILT_A_EN 3
`define CDP_CTRL_FILT_B_EN 4
`define CDP_CTRL_ST_EN 5
`define CDP_CTRL_ST_TAP_IN 6
`define CDP_CTRL_ST_TAP_OUT 7
`define CDP_CTRL_RESET 16'h0001

`define CDP_BIAS_VOLT_LSB 0
`define CDP_BIAS_CUR_LSB 4
`define CDP_BIAS_RESET 16'h0000

`define CDP_GAIN_IN_LSB 0
`define CDP_GAIN_OUT_LSB 4
`define CDP_GAIN_RESET 16'h0060
`define CDP_LINE_GAIN_CODE 4'h9

`define CDP_SIDETONE_RESET 16'h0000
`define CDP_ST_SHIFT 4

`define CDP_W_GAIN 0
`define CDP_W_B01 1
`define CDP_W_B02 2
`define CDP_W_A01 3
`define CDP_W_A02 4
`define CDP_W_B11 5
`define CDP_W_B12 6
`define CDP_W_A11 7
`define CDP_W_A12 8
`define CDP_W_DC 9
`define CDP_NUM_WORDS 10
`define CDP_FRAC 10
`define CDP_UNITY 12'h400

`endif

/* File: tb/cdp_path_monitor.sv */
// checker bound to the codec digital path top
`timescale 1ns/100ps
`include "cdp_regs.svh"
module cdp_path_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   // streams
   input wire logic adc_valid,
   input wire logic filt_valid,
   input wire logic left_out_pos,
   input wire logic left_out_neg,
   // analog controls
   input wire logic output_a,
   input wire logic [3:0] bias_voltage_code,
   input wire logic line_mode,
   input wire logic amp1_enable,
   input wire logic [3:0] in_gain_code,
   input wire logic [2:0] out_gain_code,
   input wire logic adc_a_enable,
   input wire logic adc_b_enable
);
   // outputs settle a few edges after the synchronised reset lets go
   logic [2:0] up_q;
   logic [2:0] up_d;
   always_comb begin
      up_d = (up_q == 3'h6) ? up_q : up_q + 3'h1;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         up_q <= 3'h0;
      end else begin
         up_q <= up_d;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b || up_q != 3'h6);
   sequence s_cha_off;
      (!adc_a_enable) [*3];
   endsequence
   sequence s_cha_on;
      adc_a_enable [*4];
   endsequence
   AST_FILT_STROBE: assert property (adc_valid |=> filt_valid)
      else $error("filtered strobe missing after capture strobe");
   AST_FILT_NO_EXTRA: assert property (filt_valid |-> $past(adc_valid))
      else $error("filtered strobe without capture strobe");
   AST_LINE_BY_GAIN: assert property ($stable(in_gain_code) |->
      line_mode == (in_gain_code < 4'h9))
      else $error("line mode does not follow input gain");
   AST_AMP1_OFF_LINE: assert property ($stable(line_mode) && amp1_enable
      |-> !line_mode)
      else $error("first amplifier on in line mode");
   AST_BIAS_CAPTURE: assert property (output_a && $stable(adc_a_enable)
      && $stable(adc_b_enable) |-> adc_a_enable || adc_b_enable)
      else $error("output_a on with no channel");
   AST_LEFT_COMPL: assert property (s_cha_on |->
      left_out_pos != left_out_neg)
      else $error("left bitstream pair not complementary");
   AST_LEFT_QUIET: assert property (s_cha_off |->
      !left_out_pos && !left_out_neg)
      else $error("disabled left channel still driven");
   AST_OUT_GAIN_WR: assert property ($changed(out_gain_code) |->
      ($past(reg_wr) && $past(reg_addr) == `CDP_ADDR_GAIN) ||
      ($past(reg_wr, 2) && $past(reg_addr, 2) == `CDP_ADDR_GAIN))
      else $error("output gain code changed without a write");
   AST_BIAS_WR: assert property ($changed(bias_voltage_code) |->
      ($past(reg_wr) && $past(reg_addr) == `CDP_ADDR_BIAS) ||
      ($past(reg_wr, 2) && $past(reg_addr, 2) == `CDP_ADDR_BIAS))
      else $error("bias voltage code changed without a write");
endmodule : cdp_path_monitor
bind cdp_top cdp_path_monitor u_mon (.clock(clock), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .adc_valid(adc_valid),
   .filt_valid(filt_valid), .left_out_pos(left_out_pos),
   .left_out_neg(left_out_neg), .output_a(output_a),
   .bias_voltage_code(bias_voltage_code), .line_mode(line_mode),
   .amp1_enable(amp1_enable), .in_gain_code(in_gain_code),
   .out_gain_code(out_gain_code), .adc_a_enable(adc_a_enable),
   .adc_b_enable(adc_b_enable));

/* File: tb/tb_top.sv */
// self-checking bench for the codec digital path
`timescale 1ns/100ps
module tb_top;
   logic clock, rst_b, reg_wr, reg_rd, adc_valid, dac_valid, filt_valid;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, adc_a, adc_b, filt_a, filt_b;
   logic [15:0] dac_left, dac_right;
   logic left_out_pos, left_out_neg, right_out_pos, right_out_neg;
   logic output_a, line_mode, amp1_enable, adc_a_enable, adc_b_enable;
   logic [3:0] bias_voltage_code, bias_current_code, in_gain_code;
   logic [2:0] out_gain_code;
   int fail_count, checks, cyc, nl, nr, ol, orr, v;
   int unsigned seed = 15;
   int cf[2][10];
   int st[2][8];
   int dcp[2];
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h64, 8'h20,
      8'h41};
   logic [15:0] rv[8] = '{16'h0001, 0, 16'h0060, 0, 16'h0400, 0, 0, 0};
   logic [15:0] mv[8] = '{16'h00ff, 16'h00ff, 16'h007f, 16'h000f, 16'hffff,
      16'h0001, 0, 0};

   cdp_top DUT (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_a(adc_a),
      .adc_b(adc_b), .filt_valid(filt_valid), .filt_a(filt_a),
      .filt_b(filt_b), .dac_valid(dac_valid), .dac_left(dac_left),
      .dac_right(dac_right), .left_out_pos(left_out_pos),
      .left_out_neg(left_out_neg), .right_out_pos(right_out_pos),
      .right_out_neg(right_out_neg), .output_a(output_a),
      .bias_voltage_code(bias_voltage_code),
      .bias_current_code(bias_current_code), .line_mode(line_mode),
      .amp1_enable(amp1_enable), .in_gain_code(in_gain_code),
      .out_gain_code(out_gain_code), .adc_a_enable(adc_a_enable),
      .adc_b_enable(adc_b_enable));

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic int sat(input int x);
      return (x > 32767) ? 32767 : ((x < -32768) ? -32768 : x);
   endfunction : sat
   // reference filter with the same floor shifts and saturation points
   function automatic int model(input int c, input int x);
      int s;
      int acc;
      int y;
      y = sat((cf[c][0] * x) >>> 10);
      for (s = 0; s < 8; s += 4) begin
         acc = (y <<< 10) + cf[c][s+1] * st[c][s] + cf[c][s+2] * st[c][s+1];
         acc = acc - cf[c][s+3] * st[c][s+2] - cf[c][s+4] * st[c][s+3];
         st[c][s+1] = st[c][s];
         st[c][s] = y;
         y = sat(acc >>> 10);
         st[c][s+3] = st[c][s+2];
         st[c][s+2] = y;
      end
      if (cf[c][9] != 0) begin
         acc = y;
         y = sat(y - dcp[c]);
         dcp[c] = acc;
      end
      return y;
   endfunction : model
   task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input string what, input logic [7:0] a,
      input logic [15:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(what, e, reg_rdata);
   endtask : rdchk
   task automatic cfg(input int c, input int dc);
      int a;
      for (int w = 0; w < 10; w++) begin
         a = 64 + 64 * c + 4 * w;
         cf[c][w] = int'(rnd() % 256) - 128;
         if (w == 0) cf[c][w] = 768 + int'(rnd() % 512);
         if (w == 9) cf[c][w] = dc;
         wr(8'(a), 16'(cf[c][w]));
         rdchk("filter word", 8'(a), 16'(cf[c][w]));
      end
   endtask : cfg
   task automatic smp(input int fa, input int fb);
      int xa;
      int xb;
      int ea;
      int eb;
      xa = int'(rnd() % 16384) - 8192;
      xb = int'(rnd() % 16384) - 8192;
      ea = fa ? model(0, xa) : xa;
      eb = fb ? model(1, xb) : xb;
      @(posedge clock);
      adc_valid <= 1'b1;
      adc_a <= 16'(xa);
      adc_b <= 16'(xb);
      @(posedge clock);
      adc_valid <= 1'b0;
      #1;
      chk("filt_valid", 16'h0001, {15'h0, filt_valid});
      chk("filt_a", 16'(ea), filt_a);
      chk("filt_b", 16'(eb), filt_b);
   endtask : smp
   // carries are exact over 64 cycles when the step is a multiple of 1/64
   task automatic count64(output int l, output int r);
      l = 0;
      r = 0;
      repeat (4) @(posedge clock);
      repeat (64) begin
         @(posedge clock);
         #1;
         l += left_out_pos;
         r += right_out_pos;
      end
   endtask : count64
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // the whole run needs a few hundred cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      {rst_b, reg_wr, reg_rd, adc_valid, dac_valid} = 5'h00;
      {reg_addr, reg_wdata, adc_a, adc_b, dac_left, dac_right} = '0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      foreach (ra[i]) rdchk("reset value", ra[i], rv[i]);
      foreach (ra[i]) wr(ra[i], 16'hffff);
      foreach (ra[i]) rdchk("masked value", ra[i], mv[i]);
      wr(8'h40, 16'h0800);
      rdchk("most negative word", 8'h40, 16'hf800);
      $display("test registers done");
      wr(8'h00, 16'h0007);
      for (int g = 0; g < 16; g++) begin
         wr(8'h08, 16'((g % 8) * 16 + g));
         repeat (3) @(posedge clock);
         chk("line_mode", 16'(g < 9), {15'h0, line_mode});
         chk("amp1_enable", 16'(g >= 9), {15'h0, amp1_enable});
         chk("out_gain_code", 16'(g % 8), {13'h0, out_gain_code});
         chk("in_gain_code", 16'(g), {12'h0, in_gain_code});
         rdchk("status", 8'h10, 16'(g < 9 ? 11 : 13));
      end
      for (int i = 0; i < 4; i++) begin
         v = (i < 2) ? 255 * i : int'(rnd() % 256);
         wr(8'h04, 16'(v));
         repeat (3) @(posedge clock);
         chk("bias codes", 16'(v), {8'h0, bias_current_code, bias_voltage_code});
      end
      wr(8'h00, 16'h0004);
      repeat (3) @(posedge clock);
      chk("output_a idle", 16'h0, {15'h0, output_a});
      $display("test analog controls done");
      wr(8'h00, 16'h0003);
      repeat (8) smp(0, 0);
      cfg(0, 0);
      cfg(1, 1);
      wr(8'h00, 16'h001b);
      repeat (24) smp(1, 1);
      wr(8'h00, 16'h0013);
      repeat (8) smp(0, 1);
      $display("test filters done");
      // side tone from the raw capture, gain 8/16, latched with playback
      wr(8'h0c, 16'h0008);
      wr(8'h00, 16'h0063);
      ol = int'(rnd() % 32);
      v = int'(rnd() % 16);
      orr = int'(rnd() % 64);
      @(posedge clock);
      dac_valid <= 1'b1;
      adc_a <= 16'(v * 2048);
      dac_left <= 16'(ol * 1024) ^ 16'h8000;
      dac_right <= 16'(orr * 1024) ^ 16'h8000;
      @(posedge clock);
      dac_valid <= 1'b0;
      count64(nl, nr);
      chk("left density", 16'(ol + v), 16'(nl));
      chk("right density", 16'(orr), 16'(nr));
      // live mixing adds the side tone again onto the latched sample
      wr(8'h00, 16'h00e3);
      count64(nl, nr);
      chk("left live side tone", 16'(ol + 2 * v), 16'(nl));
      wr(8'h00, 16'h0002);
      repeat (4) @(posedge clock);
      chk("left pins off", 16'h0, {14'h0, left_out_pos, left_out_neg});
      chk("channel enables", 16'h2, {14'h0, adc_b_enable, adc_a_enable});
      chk("filt_a off", 16'h0, filt_a);
      chk("right pair", 16'h1, {15'h0, right_out_pos ^ right_out_neg});
      $display("test playback done");
      test_done();
   end
endmodule : tb_top
